//--- rtl/irq_status_pkg.sv
// Shared constants and types for the core interrupt status and enable block
package irq_status_pkg;

    // ----------------------------------------
    // Register indices; the byte address is four times the index
    // ----------------------------------------
    localparam logic [7:0] IDX_STATUS_CONTROL = 8'h07;
    localparam logic [7:0] IDX_PERIPH_ENABLE_ONE = 8'h17;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h20;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h21;
    localparam logic [7:0] IDX_CORE_CONTROL = 8'h22;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int unsigned BIT_EXT_EN = 0;
    localparam int unsigned BIT_T0_EN = 1;
    localparam int unsigned BIT_TCLK_EN = 2;
    localparam int unsigned BIT_PERIPH_EN = 3;
    localparam int unsigned BIT_EXT_FLAG = 4;
    localparam int unsigned BIT_T0_FLAG = 5;
    localparam int unsigned BIT_TCLK_FLAG = 6;
    localparam int unsigned BIT_PERIPH_FLAG = 7;
    localparam int unsigned BIT_CTL_GID = 0;
    localparam int unsigned BIT_CTL_EXT_RISE = 1;
    localparam int unsigned BIT_CTL_TCLK_RISE = 2;

    // Event status bits: external edge, overflow, timer-clock edge, vector taken
    localparam int unsigned EVENT_COUNT = 4;

    // ----------------------------------------
    // Reset values and vectors
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_EVENT = 4'h0;
    localparam logic [2:0] RESET_CONTROL = 3'h1;
    localparam logic [7:0] VECTOR_EXT = 8'h08;
    localparam logic [7:0] VECTOR_T0 = 8'h10;
    localparam logic [7:0] VECTOR_TCLK = 8'h18;
    localparam logic [7:0] VECTOR_PERIPH_DEFAULT = 8'h20;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        VEC_EXT = 3'b000,
        VEC_T0 = 3'b001,
        VEC_TCLK = 3'b010,
        VEC_PERIPH = 3'b011,
        VEC_NONE = 3'b100
    } vector_sel_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

endpackage

//--- rtl/core_interrupt_status_enable.sv
// Interrupt status/control and first peripheral enable logic with APB access
// What this block does
// RULE_01: Status/control byte: three flags, summary, four enables
// RULE_02: Summary flag read-only, OR of enabled peripheral requests
// RULE_03: Timer-clock edge sets flag, vector 18h clears
// RULE_04: Timer-zero overflow sets flag, vector 10h clears
// RULE_05: External edge sets flag, vector 08h clears
// RULE_06: Group enable gates all peripheral requests
// RULE_07: Timer-clock edge enable gates its request
// RULE_08: Overflow enable gates its request
// RULE_09: External edge enable gates its request
// RULE_10: Peripheral enable byte, read/write, resets zero
// RULE_11: Port-B change enable gates its request
// RULE_12: Timer three, two, one enables gate requests
// RULE_13: Capture two and one enables gate requests
// RULE_14: Serial-one transmit and receive enables gate requests
// RULE_15: Flags set regardless of enables or global disable
// RULE_16: Response sets global disable; return clears it
// RULE_17: Software clears peripheral flags before re-enabling
// RULE_18: Core request only when global disable clear
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module core_interrupt_status_enable
    import irq_status_pkg::*;
#(
    parameter int unsigned PERIPH_COUNT = 8,
    parameter logic [7:0] VECTOR_PERIPH = VECTOR_PERIPH_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire apb_req_t i_apb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_ext_irq_pin,
    input wire logic i_tclk_input_pin,
    input wire logic i_timer_zero_overflow,
    input wire logic [PERIPH_COUNT-1:0] i_periph_req,
    input wire logic i_irq_accept,
    input wire logic i_return_from_irq_instr,
    output logic o_core_irq_req,
    output logic o_vector_load,
    output logic [7:0] o_vector_addr,
    output logic o_global_irq_disable,
    output logic o_irq
);

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    logic [1:0] ext_sync_q;
    logic [1:0] tclk_sync_q;
    logic ext_last_q;
    logic tclk_last_q;
    logic ext_edge;
    logic tclk_edge;
    logic [2:0] ctl_q;
    logic [1:0] edge_rise_q;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ext_sync_q <= 2'h0;
            tclk_sync_q <= 2'h0;
            ext_last_q <= 1'b0;
            tclk_last_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], i_ext_irq_pin};
            tclk_sync_q <= {tclk_sync_q[0], i_tclk_input_pin};
            ext_last_q <= ext_sync_q[1];
            tclk_last_q <= tclk_sync_q[1];
        end
    end

    // Edge polarity comes from the control register: 1 rising, 0 falling
    assign ext_edge = ctl_q[BIT_CTL_EXT_RISE] ? (ext_sync_q[1] & ~ext_last_q)
                                              : (~ext_sync_q[1] & ext_last_q);
    assign tclk_edge = ctl_q[BIT_CTL_TCLK_RISE] ? (tclk_sync_q[1] & ~tclk_last_q)
                                                : (~tclk_sync_q[1] & tclk_last_q);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [7:0] bus_idx;
    logic idx_hit;
    logic wr_access;
    logic wr_lane0;
    logic wr_status;
    logic wr_peripheral_enable_one;
    logic wr_evt;
    logic wr_mask;
    logic wr_ctl;

    assign bus_idx = i_apb.paddr[9:2];
    assign idx_hit = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[11:10] == 2'h0) &&
                     (bus_idx == IDX_STATUS_CONTROL || bus_idx == IDX_PERIPH_ENABLE_ONE ||
                      bus_idx == IDX_EVENT_STATUS || bus_idx == IDX_EVENT_MASK ||
                      bus_idx == IDX_CORE_CONTROL);
    assign wr_access = i_apb.psel & i_apb.penable & i_apb.pwrite & idx_hit;
    assign wr_lane0 = wr_access & i_apb.pstrb[0];
    assign wr_status = wr_lane0 && bus_idx == IDX_STATUS_CONTROL;
    assign wr_peripheral_enable_one = wr_lane0 && bus_idx == IDX_PERIPH_ENABLE_ONE;
    assign wr_evt = wr_lane0 && bus_idx == IDX_EVENT_STATUS;
    assign wr_mask = wr_lane0 && bus_idx == IDX_EVENT_MASK;
    assign wr_ctl = wr_lane0 && bus_idx == IDX_CORE_CONTROL;

    // ----------------------------------------
    // Enables and peripheral summary
    // ----------------------------------------
    logic [3:0] enable_q;
    logic [PERIPH_COUNT-1:0] peripheral_enable_one_q;
    logic peripheral_summary_flag;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            enable_q <= RESET_BYTE[3:0]; // RULE_01
        end else if (wr_status) begin
            enable_q <= i_apb.pwdata[BIT_PERIPH_EN:BIT_EXT_EN]; // RULE_01
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            peripheral_enable_one_q <= '0; // RULE_10
        end else if (wr_peripheral_enable_one) begin
            peripheral_enable_one_q <= i_apb.pwdata[PERIPH_COUNT-1:0]; // RULE_10
        end
    end

    // Each request bit meets its own enable bit; bit order is port-B change down to serial receive
    assign peripheral_summary_flag = |(i_periph_req & peripheral_enable_one_q); // RULE_02 RULE_11 RULE_12 RULE_13 RULE_14

    // ----------------------------------------
    // Directly vectored flags: ext, overflow, timer-clock
    // ----------------------------------------
    logic [2:0] flag_q;
    logic [2:0] flag_set;
    logic [2:0] flag_vec_clr;
    logic [2:0] flag_req;
    logic req_now;
    logic take;
    vector_sel_t vec_sel;

    // Set regardless of enables or global disable
    assign flag_set = {tclk_edge, i_timer_zero_overflow, ext_edge}; // RULE_15

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            // A set in the same cycle as a write or a vector clear wins
            always_ff @(posedge i_clock or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    flag_q[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flag_q[gi] <= 1'b1; // RULE_03 RULE_04 RULE_05
                end else if (flag_vec_clr[gi]) begin
                    flag_q[gi] <= 1'b0; // RULE_03 RULE_04 RULE_05
                end else if (wr_status) begin
                    flag_q[gi] <= i_apb.pwdata[BIT_EXT_FLAG + gi];
                end
            end
            assign flag_req[gi] = flag_q[gi] & enable_q[gi]; // RULE_07 RULE_08 RULE_09
        end
    endgenerate

    // ----------------------------------------
    // Request and vectoring
    // ----------------------------------------
    logic periph_req;
    logic gid_q;

    assign periph_req = peripheral_summary_flag & enable_q[BIT_PERIPH_EN]; // RULE_06
    assign req_now = ~gid_q & (|flag_req | periph_req); // RULE_18

    // Lowest vector address has priority
    always_comb begin
        if (flag_req[0]) begin
            vec_sel = VEC_EXT;
        end else if (flag_req[1]) begin
            vec_sel = VEC_T0;
        end else if (flag_req[2]) begin
            vec_sel = VEC_TCLK;
        end else if (periph_req) begin
            vec_sel = VEC_PERIPH;
        end else begin
            vec_sel = VEC_NONE;
        end
    end

    assign take = i_irq_accept & req_now;
    // Peripheral sources are left for software to clear
    assign flag_vec_clr = {take && vec_sel == VEC_TCLK, take && vec_sel == VEC_T0,
                           take && vec_sel == VEC_EXT}; // RULE_03 RULE_04 RULE_05 RULE_17

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_core_irq_req <= 1'b0;
            o_vector_load <= 1'b0;
            o_vector_addr <= RESET_BYTE;
        end else begin
            o_core_irq_req <= req_now & ~take; // RULE_18
            o_vector_load <= take; // RULE_16
            if (take) begin
                unique case (vec_sel)
                    VEC_EXT: o_vector_addr <= VECTOR_EXT;
                    VEC_T0: o_vector_addr <= VECTOR_T0;
                    VEC_TCLK: o_vector_addr <= VECTOR_TCLK;
                    VEC_PERIPH: o_vector_addr <= VECTOR_PERIPH;
                    default: o_vector_addr <= o_vector_addr;
                endcase
            end
        end
    end

    // Response forces the disable on; a return clears it unless a new response lands
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gid_q <= RESET_CONTROL[BIT_CTL_GID];
        end else if (take) begin
            gid_q <= 1'b1; // RULE_16
        end else if (i_return_from_irq_instr) begin
            gid_q <= 1'b0; // RULE_16
        end else if (wr_ctl) begin
            gid_q <= i_apb.pwdata[BIT_CTL_GID];
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            edge_rise_q <= RESET_CONTROL[BIT_CTL_TCLK_RISE:BIT_CTL_EXT_RISE];
        end else if (wr_ctl) begin
            edge_rise_q <= i_apb.pwdata[BIT_CTL_TCLK_RISE:BIT_CTL_EXT_RISE];
        end
    end
    // One driver for the whole control word keeps the disable bit owned by its own process
    assign ctl_q = {edge_rise_q, gid_q};
    assign o_global_irq_disable = gid_q;

    // ----------------------------------------
    // Event status, mask and interrupt line
    // ----------------------------------------
    logic [EVENT_COUNT-1:0] evt_q;
    logic [EVENT_COUNT-1:0] evt_set;
    logic [EVENT_COUNT-1:0] mask_q;

    assign evt_set = {take, tclk_edge, i_timer_zero_overflow, ext_edge};

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            evt_q <= RESET_EVENT;
            mask_q <= RESET_EVENT;
        end else begin
            // Write-one-to-clear; a set in the same cycle survives
            evt_q <= (evt_q & ~(wr_evt ? i_apb.pwdata[EVENT_COUNT-1:0] : RESET_EVENT)) | evt_set;
            if (wr_mask) begin
                mask_q <= i_apb.pwdata[EVENT_COUNT-1:0];
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(evt_q & mask_q);
        end
    end

    // ----------------------------------------
    // APB answer: zero wait states, read data latched in setup
    // ----------------------------------------
    logic [7:0] status_byte;
    logic [31:0] rd_word;

    assign status_byte = {peripheral_summary_flag, flag_q, enable_q}; // RULE_01 RULE_02

    always_comb begin
        rd_word = ZERO_WORD;
        if (bus_idx == IDX_STATUS_CONTROL) begin
            rd_word[7:0] = status_byte;
        end else if (bus_idx == IDX_PERIPH_ENABLE_ONE) begin
            rd_word[PERIPH_COUNT-1:0] = peripheral_enable_one_q;
        end else if (bus_idx == IDX_EVENT_STATUS) begin
            rd_word[EVENT_COUNT-1:0] = evt_q;
        end else if (bus_idx == IDX_EVENT_MASK) begin
            rd_word[EVENT_COUNT-1:0] = mask_q;
        end else if (bus_idx == IDX_CORE_CONTROL) begin
            rd_word[2:0] = ctl_q;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pready <= 1'b0;
            o_prdata <= ZERO_WORD;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= 1'b1;
            if (i_apb.psel && !i_apb.penable) begin
                o_prdata <= (!i_apb.pwrite && idx_hit) ? rd_word : ZERO_WORD;
                o_pslverr <= ~idx_hit;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    property p_ext_set;
        ext_edge |=> flag_q[0];
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("ext flag not set"); // RULE_05

    property p_t0_set;
        i_timer_zero_overflow |=> flag_q[1];
    endproperty
    a_t0_set: assert property (p_t0_set) else $error("overflow flag not set"); // RULE_04

    property p_tclk_set;
        tclk_edge |=> flag_q[2];
    endproperty
    a_tclk_set: assert property (p_tclk_set) else $error("tclk flag not set"); // RULE_03

    property p_vec_clear;
        (take && vec_sel == VEC_EXT && !ext_edge) |=> !flag_q[0] && o_vector_addr == VECTOR_EXT;
    endproperty
    a_vec_clear: assert property (p_vec_clear) else $error("ext vector did not clear flag"); // RULE_05

    property p_gid_on_take;
        take |=> gid_q && o_vector_load ##1 !o_vector_load;
    endproperty
    a_gid_on_take: assert property (p_gid_on_take) else $error("response did not disable"); // RULE_16

    property p_return;
        (i_return_from_irq_instr && !take) |=> !o_global_irq_disable;
    endproperty
    a_return: assert property (p_return) else $error("return did not clear disable"); // RULE_16

    property p_gid_blocks;
        gid_q |=> !o_core_irq_req;
    endproperty
    a_gid_blocks: assert property (p_gid_blocks) else $error("request while disabled"); // RULE_18

    property p_group_block;
        (!enable_q[BIT_PERIPH_EN] && !(|flag_req)) |=> !o_core_irq_req;
    endproperty
    a_group_block: assert property (p_group_block) else $error("peripheral passed group"); // RULE_06

    property p_enable_req;
        (!gid_q && flag_q[1] && enable_q[1] && !i_irq_accept) |=> o_core_irq_req;
    endproperty
    a_enable_req: assert property (p_enable_req) else $error("enabled overflow not requested"); // RULE_08

    property p_peripheral_enable_one_write;
        wr_peripheral_enable_one |=> peripheral_enable_one_q == $past(i_apb.pwdata[PERIPH_COUNT-1:0]);
    endproperty
    a_peripheral_enable_one_write: assert property (p_peripheral_enable_one_write) else $error("enable byte not written"); // RULE_10

    property p_irq_line;
        (|(evt_q & mask_q)) |=> o_irq;
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("interrupt line low"); // RULE_15

    c_periph_take: cover property (take && vec_sel == VEC_PERIPH);
    c_ext_take: cover property (take && vec_sel == VEC_EXT);
    c_set_over_clear: cover property (wr_status && |flag_set);
    c_return: cover property (o_vector_load ##[1:20] i_return_from_irq_instr);

endmodule

//--- verif/core_partner_model.sv
// Core sequencer and peripheral request source model facing the interrupt block
`timescale 1ns/10ps
module core_partner_model
    import irq_status_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_vector_load,
    input wire logic [7:0] i_vector_addr,
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic i_req_load,
    input wire logic [7:0] i_req_value,
    output logic o_irq_accept,
    output logic o_return_from_irq_instr,
    output logic [7:0] o_periph_req
);
    logic [2:0] boundary_q;
    logic [2:0] service_q;

    // ----------------------------------------
    // Instruction boundaries
    // ----------------------------------------
    // Slow mode opens a boundary one cycle in eight, like a run of long instructions
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            boundary_q <= 3'h0;
            o_irq_accept <= 1'b0;
        end else begin
            boundary_q <= boundary_q + 3'h1;
            o_irq_accept <= i_run && (!i_slow || boundary_q == 3'h7);
        end
    end

    // ----------------------------------------
    // Service routine and return
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            service_q <= 3'h0;
            o_return_from_irq_instr <= 1'b0;
        end else begin
            o_return_from_irq_instr <= 1'b0;
            if (i_vector_load) begin
                service_q <= 3'h5;
            end else if (service_q != 3'h0) begin
                service_q <= service_q - 3'h1;
                o_return_from_irq_instr <= (service_q == 3'h1);
            end
        end
    end

    // ----------------------------------------
    // Peripheral sources
    // ----------------------------------------
    // The shared vector leaves sources set, so the routine clears them before returning
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_periph_req <= 8'h00;
        end else if (i_vector_load && i_vector_addr == VECTOR_PERIPH_DEFAULT) begin
            o_periph_req <= 8'h00;
        end else if (i_req_load) begin
            o_periph_req <= i_req_value;
        end
    end
endmodule

//--- verif/core_interrupt_status_enable_tb.sv
// Self-checking bench for the core interrupt status and enable block
`timescale 1ns/10ps
module core_interrupt_status_enable_tb
    import irq_status_pkg::*;
;
    logic i_clock;
    logic i_sys_rst;
    apb_req_t apb;
    logic pready, pslverr, ext_pin, tclk_pin, t0_ovf, accept, ret, core_req, vec_load, gid, irq;
    logic run, slow, req_load;
    logic [31:0] prdata, rd_word;
    logic [7:0] periph_req, vec_addr, req_value, en, rq;
    logic rd_err;
    logic [15:0] lfsr;
    logic [7:0] vec_seen[$];
    int num_errors, checked, n;

    core_interrupt_status_enable uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_apb(apb),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_ext_irq_pin(ext_pin),
        .i_tclk_input_pin(tclk_pin), .i_timer_zero_overflow(t0_ovf), .i_periph_req(periph_req),
        .i_irq_accept(accept), .i_return_from_irq_instr(ret), .o_core_irq_req(core_req),
        .o_vector_load(vec_load), .o_vector_addr(vec_addr), .o_global_irq_disable(gid), .o_irq(irq));

    core_partner_model partner (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_vector_load(vec_load),
        .i_vector_addr(vec_addr), .i_run(run), .i_slow(slow), .i_req_load(req_load),
        .i_req_value(req_value), .o_irq_accept(accept), .o_return_from_irq_instr(ret),
        .o_periph_req(periph_req));

    always #2 i_clock = ~i_clock;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] l);
        return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
    endfunction

    function automatic logic summary_exp(input logic [7:0] r, input logic [7:0] e);
        return |(r & e);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; two idle edges follow so registered outputs have settled before a check
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int k;
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: d, pstrb: 4'hf};
        @(posedge i_clock);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (pready !== 1'b1) begin
            num_errors++;
            test_done();
        end
        rd_word = prdata;
        rd_err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask

    task automatic load_req(input logic [7:0] v);
        req_value <= v;
        req_load <= 1'b1;
        @(posedge i_clock);
        req_load <= 1'b0;
    endtask

    always @(posedge i_clock) begin
        if (vec_load === 1'b1) begin
            vec_seen.push_back(vec_addr);
            check(gid, 1'b1);
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        i_clock = 1'b0;
        i_sys_rst = 1'b1;
        apb = '0;
        {ext_pin, tclk_pin, t0_ovf, run, slow, req_load} = 6'h00;
        req_value = 8'h00;
        lfsr = 16'h57ea;
        repeat (8) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        xfer(1'b0, IDX_STATUS_CONTROL, 32'h0);
        check(rd_word, 32'h0);
        xfer(1'b0, IDX_PERIPH_ENABLE_ONE, 32'h0);
        check(rd_word, 32'h0);
        xfer(1'b0, IDX_CORE_CONTROL, 32'h0);
        check(rd_word, 32'h1);
        // Unmapped index must be refused
        xfer(1'b0, 8'h30, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        // Summary flag: each enable alone, with all requests set on odd bits and only the other requests on even bits, then random mixes
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            en = (i < 8) ? (8'h01 << i) : lfsr[7:0];
            rq = (i < 8) ? ((i % 2 == 1) ? 8'hff : ~en) : lfsr[15:8];
            load_req(rq);
            xfer(1'b1, IDX_PERIPH_ENABLE_ONE, {24'h0, en});
            xfer(1'b0, IDX_PERIPH_ENABLE_ONE, 32'h0);
            check(rd_word, {24'h0, en});
            xfer(1'b0, IDX_STATUS_CONTROL, 32'h0);
            check(rd_word[7], summary_exp(rq, en));
        end
        // Flags set with enables off and global disable on, rising edges selected
        load_req(8'h00);
        xfer(1'b1, IDX_CORE_CONTROL, 32'h7);
        ext_pin <= 1'b1;
        tclk_pin <= 1'b1;
        t0_ovf <= 1'b1;
        @(posedge i_clock);
        t0_ovf <= 1'b0;
        repeat (8) @(posedge i_clock);
        xfer(1'b0, IDX_STATUS_CONTROL, 32'h0);
        check(rd_word, 32'h70);
        xfer(1'b0, IDX_EVENT_STATUS, 32'h0);
        check(rd_word, 32'h7);
        xfer(1'b1, IDX_EVENT_MASK, 32'h1);
        check(irq, 1'b1);
        xfer(1'b1, IDX_EVENT_STATUS, 32'h1);
        xfer(1'b0, IDX_EVENT_STATUS, 32'h0);
        check(rd_word, 32'h6);
        check(irq, 1'b0);
        xfer(1'b1, IDX_EVENT_MASK, 32'h0);
        // Falling edges selected
        xfer(1'b1, IDX_STATUS_CONTROL, 32'h0);
        xfer(1'b1, IDX_CORE_CONTROL, 32'h1);
        ext_pin <= 1'b0;
        tclk_pin <= 1'b0;
        repeat (8) @(posedge i_clock);
        xfer(1'b0, IDX_STATUS_CONTROL, 32'h0);
        check(rd_word, 32'h50);
        // No request while globally disabled, then per-enable gating
        xfer(1'b1, IDX_STATUS_CONTROL, 32'h77);
        repeat (3) @(posedge i_clock);
        check(core_req, 1'b0);
        xfer(1'b1, IDX_CORE_CONTROL, 32'h6);
        for (int b = 0; b < 3; b++) begin
            xfer(1'b1, IDX_STATUS_CONTROL, 32'h70);
            check(core_req, 1'b0);
            xfer(1'b1, IDX_STATUS_CONTROL, 32'h70 | (32'h1 << b));
            check(core_req, 1'b1);
        end
        xfer(1'b1, IDX_PERIPH_ENABLE_ONE, 32'h1);
        load_req(8'h01);
        xfer(1'b1, IDX_STATUS_CONTROL, 32'h0);
        check(core_req, 1'b0);
        xfer(1'b1, IDX_STATUS_CONTROL, 32'h8);
        check(core_req, 1'b1);
        // Vectoring, prompt then slow core
        for (int p = 0; p < 2; p++) begin
            vec_seen.delete();
            load_req(8'h01);
            slow <= p[0];
            xfer(1'b1, IDX_STATUS_CONTROL, 32'h7f);
            run <= 1'b1;
            n = 0;
            do begin
                @(posedge i_clock);
                n++;
            end while (!(vec_seen.size() == 4 && gid === 1'b0) && n < 600);
            run <= 1'b0;
            if (!(vec_seen.size() == 4 && gid === 1'b0)) begin
                num_errors++;
            end
            check(vec_seen.size(), 4);
            for (int v = 0; v < vec_seen.size() && v < 4; v++) begin
                check(vec_seen[v], ({VECTOR_EXT, VECTOR_T0, VECTOR_TCLK, VECTOR_PERIPH_DEFAULT} >> (24 - 8 * v)) & 32'hff);
            end
            check(gid, 1'b0);
            xfer(1'b0, IDX_STATUS_CONTROL, 32'h0);
            check(rd_word, 32'h0f);
        end
        // Reset after the vectoring runs returns the status byte, peripheral enable byte and disable bit to their power-on values
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        xfer(1'b0, IDX_STATUS_CONTROL, 32'h0);
        check(rd_word, 32'h0);
        xfer(1'b0, IDX_PERIPH_ENABLE_ONE, 32'h0);
        check(rd_word, 32'h0);
        check(gid, 1'b1);
        test_done();
    end
endmodule
